//--- common/sce_pkg.sv
/*
 * Shared constants and carriers of the serial EEPROM command front end.
 * Assumes one system clock of 100 MHz; all serial pins arrive asynchronously.
 */
package sce_pkg;

   // Instruction codes, bit 3 masked away before compare
   localparam logic [7:0] OPC_MASK   = 8'hf7;
   localparam logic [7:0] OPC_SETWE  = 8'h06;
   localparam logic [7:0] OPC_CLRWE  = 8'h04;
   localparam logic [7:0] OPC_RDST   = 8'h05;
   localparam logic [7:0] OPC_WRST   = 8'h01;
   localparam logic [7:0] OPC_READ   = 8'h03;
   localparam logic [7:0] OPC_WRITE  = 8'h02;

   // Status register field positions
   localparam int ST_PEN_BIT = 7;
   localparam int ST_BPH_BIT = 3;
   localparam int ST_BPL_BIT = 2;

   // Status read while programming
   localparam logic [7:0] ST_ALL_BUSY = 8'hff;

   // Delivered values of the nonvolatile protection cells
   localparam logic [1:0] BP_RESET  = 2'b00;
   localparam logic       PEN_RESET = 1'b0;

   // Lower bounds of the guarded regions; the top is always the last byte
   localparam logic [13:0] PROT_Q_BASE = 14'h3000;
   localparam logic [13:0] PROT_H_BASE = 14'h2000;

   // Array geometry
   localparam int ARRAY_BYTES = 16384;
   localparam int PAGE_BYTES  = 64;

   // Self-timed programming time
   localparam int PROG_TIME_NS     = 5000000;
   localparam int CLK_PERIOD_NS    = 10;
   localparam int PROG_CYCLES_DFLT = PROG_TIME_NS / CLK_PERIOD_NS;

   // Command phase, Gray along opcode, address, write data
   typedef enum logic [2:0] {
      PH_OPC   = 3'b000,
      PH_ADDR  = 3'b001,
      PH_WDATA = 3'b011,
      PH_RDATA = 3'b010,
      PH_STAT  = 3'b110,
      PH_SKIP  = 3'b111,
      PH_END   = 3'b100
   } sce_phase_t;

   // Serial pins as one group
   typedef struct packed {
      logic csn;
      logic sck;
      logic si;
      logic holdn;
      logic wpn;
   } sce_pins_t;

   // Whole state of the front end
   typedef struct packed {
      sce_pins_t   s1;
      sce_pins_t   s2;
      logic        sckPrev;
      logic        csPrev;
      sce_phase_t  phase;
      logic [2:0]  bitCnt;
      logic [7:0]  rxShift;
      logic [7:0]  opc;
      logic [1:0]  byteCnt;
      logic [15:0] addrShift;
      logic [13:0] addr;
      logic [7:0]  tx;
      logic        soOut;
      logic        soOen;
      logic        soOn;
      logic        wel;
      logic        protect_enable_bit;
      logic [1:0]  bp;
      logic        busy;
      logic [19:0] progCnt;
      logic        progArray;
      logic [2:0]  pendStat;
      logic [63:0] mask;
      logic [6:0]  copyIdx;
      logic        dataSeen;
      logic        dropped;
   } sce_state_t;

endpackage : sce_pkg

//--- verilog/sce_eeprom_front.sv
/*
 * Serial EEPROM command front end with write FIFO and array storage.
 * Assumes pins come straight from the bus master, asynchronous to clk_sys,
 * and that the serial clock is much slower than clk_sys (at least 4x).
 */
`timescale 1ns/1ps

module sce_fifo #(
   parameter int W = 14,
   parameter int D = 8
) (
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rstn,
   // Filling side
   input  wire logic         inValid,
   output logic              inReady,
   input  wire logic [W-1:0] inData,
   // Draining side
   output logic              outValid,
   input  wire logic         outReady,
   output logic [W-1:0]      outData
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } sce_fptr_t;

   sce_fptr_t      st;
   sce_fptr_t      next_st;
   logic [W-1:0]   slots [D];

   // Full and empty from pointer compare
   always_comb begin
      outValid = (st.wp != st.rp);
      inReady  = !((st.wp[AW-1:0] == st.rp[AW-1:0]) && (st.wp[AW] != st.rp[AW]));
      outData  = slots[st.rp[AW-1:0]];
      next_st  = st;
      if (inValid && inReady) begin
         next_st.wp = st.wp + 1'b1;
      end
      if (outValid && outReady) begin
         next_st.rp = st.rp + 1'b1;
      end
   end

   // Pointer registers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Storage
   always_ff @(posedge clk_sys) begin
      if (inValid && inReady) begin
         slots[st.wp[AW-1:0]] <= inData;
      end
   end
endmodule : sce_fifo

module sce_eeprom_front
   import sce_pkg::*;
#(
   parameter logic [19:0] PROG_CYCLES = 20'(PROG_CYCLES_DFLT),
   parameter int          FIFO_DEPTH  = 8
) (
   // System
   input  wire logic clk_sys,
   input  wire logic rstn,
   // Serial pins
   input  wire logic csn,
   input  wire logic sck,
   input  wire logic si,
   input  wire logic holdn,
   input  wire logic wpn,
   output logic      so,
   output logic      soOen,
   // Observation
   output logic      progBusy
);
   sce_state_t  st;
   sce_state_t  next_st;
   logic [7:0]  cells   [ARRAY_BYTES];
   logic [7:0]  pageBuf [PAGE_BYTES];
   logic        sckRise, sckFall, csRise, hwProt, byteDone;
   logic [7:0]  rxNext, cmd;
   logic [13:0] memWaddr, addrFull, copyAddr;
   logic        memWe;
   logic        fInValid, fInReady, fOutValid, fOutReady;
   logic [13:0] fInData, fOutData;

   // Status byte as read out
   function automatic logic [7:0] statusByte(input sce_state_t s);
      if (s.busy) begin
         return ST_ALL_BUSY;
      end
      return {s.protect_enable_bit, 3'b000, s.bp, s.wel, 1'b0};
   endfunction : statusByte

   // Whether an address lies in the guarded block
   function automatic logic guarded(input logic [1:0] bp, input logic [13:0] a);
      unique case (bp)
         2'b00:   return 1'b0;
         2'b01:   return a >= PROT_Q_BASE;
         2'b10:   return a >= PROT_H_BASE;
         default: return 1'b1;
      endcase
   endfunction : guarded

   // Write bytes with their page offsets
   sce_fifo #(
      .W (14),
      .D (FIFO_DEPTH)
   ) u_wfifo (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .inValid  (fInValid),
      .inReady  (fInReady),
      .inData   (fInData),
      .outValid (fOutValid),
      .outReady (fOutReady),
      .outData  (fOutData)
   );

   // Edge detection on synchronised pins, suspend masks the clock
   assign sckRise  = st.s2.sck & ~st.sckPrev & ~st.s2.csn & st.s2.holdn;
   assign sckFall  = ~st.s2.sck & st.sckPrev & ~st.s2.csn & st.s2.holdn;
   assign csRise   = st.s2.csn & ~st.csPrev;
   assign hwProt   = ~st.s2.wpn & st.protect_enable_bit;
   assign rxNext   = {st.rxShift[6:0], st.s2.si};
   assign byteDone = (st.bitCnt == 3'd7);
   assign cmd      = rxNext & OPC_MASK;
   assign addrFull = {st.addrShift[12:0], st.s2.si};
   assign copyAddr = {st.addr[13:6], st.copyIdx[5:0]};
   // Drain stalls once the page copy has begun
   assign fOutReady = (st.copyIdx == 7'd0) || !st.busy;

   // Next-state logic
   always_comb begin
      next_st         = st;
      next_st.s1      = '{csn: csn, sck: sck, si: si, holdn: holdn, wpn: wpn};
      next_st.s2      = st.s1;
      next_st.sckPrev = st.s2.sck;
      next_st.csPrev  = st.s2.csn;
      memWe           = 1'b0;
      memWaddr        = copyAddr;
      fInValid        = 1'b0;
      fInData         = {st.addr[5:0], rxNext};

      // Deselected: frame state returns to idle
      if (st.s2.csn) begin
         next_st.phase   = PH_OPC;
         next_st.bitCnt  = 3'd0;
         next_st.byteCnt = 2'd0;
         next_st.soOn    = 1'b0;
      end

      // Rising serial clock: take one input bit
      if (sckRise) begin
         next_st.rxShift = rxNext;
         next_st.bitCnt  = st.bitCnt + 3'd1;
         unique case (st.phase)
            PH_OPC: begin
               if (byteDone) begin
                  next_st.opc      = cmd;
                  next_st.byteCnt  = 2'd0;
                  next_st.dataSeen = 1'b0;
                  next_st.dropped  = 1'b0;
                  if (st.busy && cmd != OPC_RDST) begin
                     next_st.phase = PH_SKIP;
                  end else if (cmd == OPC_SETWE || cmd == OPC_CLRWE) begin
                     next_st.phase = PH_END;
                  end else if (cmd == OPC_RDST) begin
                     next_st.phase = PH_STAT;
                     next_st.tx    = statusByte(st);
                  end else if (cmd == OPC_WRST) begin
                     next_st.phase = PH_WDATA;
                  end else if (cmd == OPC_READ || cmd == OPC_WRITE) begin
                     next_st.phase = PH_ADDR;
                     next_st.mask  = '0;
                  end else begin
                     next_st.phase = PH_SKIP;
                  end
               end
            end
            PH_ADDR: begin
               next_st.addrShift = {st.addrShift[14:0], st.s2.si};
               if (byteDone) begin
                  next_st.byteCnt = st.byteCnt + 2'd1;
                  if (st.byteCnt == 2'd1) begin
                     next_st.byteCnt = 2'd0;
                     if (st.opc == OPC_READ) begin
                        next_st.tx    = cells[addrFull];
                        next_st.addr  = addrFull + 14'd1;
                        next_st.phase = PH_RDATA;
                     end else begin
                        next_st.addr  = addrFull;
                        next_st.phase = PH_WDATA;
                     end
                  end
               end
            end
            PH_WDATA: begin
               if (byteDone) begin
                  next_st.dataSeen = 1'b1;
                  next_st.byteCnt  = st.byteCnt + ((st.byteCnt != 2'd3) ? 2'd1 : 2'd0);
                  if (st.byteCnt == 2'd0) begin
                     next_st.addrShift[7:0] = rxNext;
                  end
                  if (st.opc == OPC_WRITE) begin
                     fInValid = 1'b1;
                     // A byte the FIFO cannot take spoils the whole write
                     if (!fInReady) begin
                        next_st.dropped = 1'b1;
                     end
                     next_st.addr = {st.addr[13:6], st.addr[5:0] + 6'd1};
                  end
               end
            end
            PH_STAT: begin
               if (byteDone) begin
                  next_st.tx = statusByte(st);
               end
            end
            PH_RDATA: begin
               if (byteDone) begin
                  next_st.tx   = cells[st.addr];
                  next_st.addr = st.addr + 14'd1;
               end
            end
            PH_END: begin
               next_st.phase = PH_SKIP;
            end
            PH_SKIP: begin
               next_st.phase = PH_SKIP;
            end
            default: begin
               next_st.phase = PH_SKIP;
            end
         endcase
      end

      // Falling serial clock: next output bit, MSB first
      if (sckFall && (st.phase == PH_STAT || st.phase == PH_RDATA)) begin
         next_st.soOut = st.tx[7];
         next_st.tx    = {st.tx[6:0], 1'b0};
         next_st.soOn  = 1'b1;
      end

      // Output enable low only while driving, selected and not suspended
      next_st.soOen = ~(next_st.soOn & ~st.s2.csn & st.s2.holdn);

      // FIFO drain into the page buffer
      if (fOutValid && fOutReady) begin
         next_st.mask[fOutData[13:8]] = 1'b1;
      end

      // Programming cycle countdown and page copy
      if (st.busy) begin
         next_st.progCnt = st.progCnt - 20'd1;
         if (st.progArray && !st.copyIdx[6] && !fOutValid) begin
            if (st.mask[st.copyIdx[5:0]] && !guarded(st.bp, copyAddr)) begin
               memWe = 1'b1;
            end
            next_st.copyIdx = st.copyIdx + 7'd1;
         end
         if (st.progCnt == 20'd1) begin
            next_st.busy = 1'b0;
            if (!st.progArray) begin
               {next_st.protect_enable_bit, next_st.bp} = st.pendStat;
            end
         end
      end

      // Chip select rise completes the instruction
      if (csRise) begin
         if (st.phase == PH_END && st.opc == OPC_SETWE) begin
            next_st.wel = 1'b1;
         end
         if (st.phase == PH_END && st.opc == OPC_CLRWE) begin
            next_st.wel = 1'b0;
         end
         if (st.phase == PH_WDATA && st.bitCnt == 3'd0 && st.opc == OPC_WRST && st.byteCnt == 2'd1) begin
            next_st.wel = 1'b0;
            if (st.wel && !hwProt) begin
               next_st.busy      = 1'b1;
               next_st.progCnt   = PROG_CYCLES;
               next_st.progArray = 1'b0;
               next_st.pendStat  = {st.addrShift[ST_PEN_BIT], st.addrShift[ST_BPH_BIT], st.addrShift[ST_BPL_BIT]};
            end
         end
         if (st.phase == PH_WDATA && st.bitCnt == 3'd0 && st.opc == OPC_WRITE && st.dataSeen
             && !st.dropped) begin
            next_st.wel = 1'b0;
            if (st.wel) begin
               next_st.busy      = 1'b1;
               next_st.progCnt   = PROG_CYCLES;
               next_st.progArray = 1'b1;
               next_st.copyIdx   = 7'd0;
            end
         end
      end
   end

   // State register; reset is power-up with delivered guard values
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st       <= '0;
         st.s1    <= '{csn: 1'b1, sck: 1'b0, si: 1'b0, holdn: 1'b1, wpn: 1'b1};
         st.s2    <= '{csn: 1'b1, sck: 1'b0, si: 1'b0, holdn: 1'b1, wpn: 1'b1};
         st.csPrev <= 1'b1;
         st.phase <= PH_OPC;
         st.soOen <= 1'b1;
         st.wel   <= 1'b0;
         st.bp    <= BP_RESET;
         st.protect_enable_bit  <= PEN_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Array and page buffer storage
   always_ff @(posedge clk_sys) begin
      if (memWe) begin
         cells[memWaddr] <= pageBuf[st.copyIdx[5:0]];
      end
      if (fOutValid && fOutReady) begin
         pageBuf[fOutData[13:8]] <= fOutData[7:0];
      end
   end

   assign so       = st.soOut;
   assign soOen    = st.soOen;
   assign progBusy = st.busy;

   // Checks
   AST_SO_HIZ_DESEL: assert property (@(posedge clk_sys) disable iff (!rstn)
      st.s2.csn |=> soOen) else $error("output driven while deselected");
   AST_HOLD_FREEZE: assert property (@(posedge clk_sys) disable iff (!rstn)
      (!st.s2.holdn && !st.s2.csn) |=> ($stable(st.bitCnt) && soOen)) else $error("activity during suspend");
   AST_BUSY_ONES: assert property (@(posedge clk_sys) disable iff (!rstn)
      (sckRise && st.busy && st.phase == PH_STAT && byteDone) |=> st.tx == 8'hff) else $error("busy status not ones");
   AST_BUSY_REJECT: assert property (@(posedge clk_sys) disable iff (!rstn)
      (sckRise && st.busy && st.phase == PH_OPC && byteDone && cmd != OPC_RDST) |=> st.phase == PH_SKIP)
      else $error("instruction accepted while busy");
   AST_WEL_SET: assert property (@(posedge clk_sys) disable iff (!rstn)
      (csRise && st.phase == PH_END && st.opc == OPC_SETWE) |=> st.wel) else $error("enable latch not set");
   AST_WEL_CLR: assert property (@(posedge clk_sys) disable iff (!rstn)
      (csRise && st.phase == PH_END && st.opc == OPC_CLRWE) |=> !st.wel) else $error("enable latch not cleared");
   AST_NO_WEL_NO_PROG: assert property (@(posedge clk_sys) disable iff (!rstn)
      (!st.wel && !st.busy) |=> !st.busy) else $error("programming without enable");
   AST_STATUS_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
      !(st.busy && st.progCnt == 20'd1 && !st.progArray) |=> $stable({st.protect_enable_bit, st.bp}))
      else $error("status changed outside cycle end");
   AST_PROG_LEN: assert property (@(posedge clk_sys) disable iff (!rstn)
      $rose(st.busy) |-> st.busy[*8]) else $error("programming cycle too short");
   AST_BAD_OPC: assert property (@(posedge clk_sys) disable iff (!rstn)
      (sckRise && st.phase == PH_OPC && byteDone && cmd != OPC_SETWE && cmd != OPC_CLRWE && cmd != OPC_RDST
       && cmd != OPC_WRST && cmd != OPC_READ && cmd != OPC_WRITE) |=> st.phase == PH_SKIP)
      else $error("unknown opcode not skipped");
   AST_SO_ON_FALL: assert property (@(posedge clk_sys) disable iff (!rstn)
      $changed(st.soOut) |-> $past(sckFall)) else $error("output moved off a falling edge");
endmodule : sce_eeprom_front

//--- bench/sce_spi_master.sv
/*
 * Bus master model that frames instructions on the serial pins.
 * Assumes clk_sys at 100 MHz; the serial clock is 80 ns and idles between frames.
 */
`timescale 1ns/1ps

module sce_spi_master (
   // Clock
   input  wire logic clk_sys,
   // Serial pins
   output logic      csn,
   output logic      sck,
   output logic      si,
   output logic      holdn,
   input  wire logic soWire
);
   logic mode3;

   // Idle pins at time zero
   initial begin
      mode3 = 1'b0;
      csn   = 1'b1;
      sck   = 1'b0;
      si    = 1'b0;
      holdn = 1'b1;
   end

   // Half a serial clock period
   task automatic half();
      repeat (4) @(posedge clk_sys);
   endtask : half

   // Idle clock level, mode 0 or 3
   task automatic setMode(input logic m);
      mode3 = m;
      sck   <= m;
      half();
   endtask : setMode

   // One frame; read bits taken late in the high phase
   task automatic xfer(input logic [7:0] tx[$], input int nRx, input int holdAt, output logic [7:0] rx[$]);
      logic [7:0] b;
      rx = {};
      csn <= 1'b0;
      half();
      for (int i = 0; i < tx.size() + nRx; i++) begin
         b = (i < tx.size()) ? tx[i] : 8'h00;
         for (int k = 7; k >= 0; k--) begin
            sck <= 1'b0;
            si  <= b[k];
            if (i * 8 + 7 - k == holdAt) begin
               half();
               holdn <= 1'b0;
               repeat (2) begin
                  half();
                  sck <= 1'b1;
                  si  <= ~b[k];
                  half();
                  sck <= 1'b0;
               end
               half();
               holdn <= 1'b1;
               si    <= b[k];
            end
            half();
            sck <= 1'b1;
            half();
            b[k] = soWire;
         end
         if (i >= tx.size()) rx.push_back(b);
      end
      if (!mode3) sck <= 1'b0;
      half();
      csn <= 1'b1;
      half();
      half();
   endtask : xfer
endmodule : sce_spi_master

//--- bench/spi_eeprom_command_protect_tb.sv
/*
 * Self-checking bench of the serial EEPROM front end against an associative array model.
 * Assumes the master model frames every instruction and so idles toggling.
 */
`timescale 1ns/1ps

module spi_eeprom_command_protect_tb;
   import sce_pkg::*;
   logic       clk_sys = 1'b0;
   logic       rstn    = 1'b0;
   logic       wpn     = 1'b1;
   logic       tog     = 1'b0;
   logic       csn, sck, si, holdn, so, soOen, progBusy, soWire;
   logic       wel = 1'b0, pen = 1'b0;
   logic [1:0] bp  = 2'b00;
   logic [7:0] mem [int];
   logic [7:0] rx[$];
   int         mismatches = 0;
   int         compares   = 0;

   // Clock and released output line
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) tog <= ~tog;
   assign soWire = (soOen === 1'b0) ? so : tog;

   sce_spi_master u_mst (.clk_sys(clk_sys), .csn(csn), .sck(sck), .si(si), .holdn(holdn), .soWire(soWire));
   sce_eeprom_front #(.PROG_CYCLES(20'd400), .FIFO_DEPTH(8)) u_dut (.clk_sys(clk_sys), .rstn(rstn),
      .csn(csn), .sck(sck), .si(si), .holdn(holdn), .wpn(wpn), .so(so), .soOen(soOen), .progBusy(progBusy));

   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   // Bounded wait for programming end
   task automatic waitIdle();
      int n;
      n = 0;
      while (progBusy !== 1'b0 && n < 800) begin
         @(posedge clk_sys);
         n++;
      end
      if (n == 800) mismatches++;
   endtask : waitIdle

   task automatic we();
      u_mst.xfer('{OPC_SETWE}, 0, -1, rx);
      wel = 1'b1;
   endtask : we

   task automatic rdst(input int h);
      u_mst.xfer('{OPC_RDST}, 2, h, rx);
      check(rx[0], {pen, 3'b000, bp, wel, 1'b0});
      check(rx[1], {pen, 3'b000, bp, wel, 1'b0});
   endtask : rdst

   task automatic rd(input logic [15:0] a, input int n);
      u_mst.xfer('{OPC_READ, a[15:8], a[7:0]}, n, -1, rx);
      for (int j = 0; j < n; j++)
         if (mem.exists(14'(a + j))) check(rx[j], mem[14'(a + j)]);
   endtask : rd

   // Page write, model updated from the guard setting
   task automatic wr(input logic [15:0] a, input logic [7:0] d[$]);
      logic [7:0]  tx[$];
      logic [13:0] p;
      logic        go;
      tx = '{OPC_WRITE, a[15:8], a[7:0]};
      go = wel && bp == 2'b00;
      foreach (d[j]) begin
         tx.push_back(d[j]);
         p = {a[13:6], 6'(a[5:0] + j)};
         if (wel && !(bp == 2'b11 || (bp == 2'b10 && p >= PROT_H_BASE) || (bp == 2'b01 && p >= PROT_Q_BASE)))
            mem[p] = d[j];
      end
      u_mst.xfer(tx, 0, -1, rx);
      wel = 1'b0;
      if (go) begin
         u_mst.xfer('{OPC_SETWE}, 0, -1, rx);
         u_mst.xfer('{OPC_RDST}, 1, -1, rx);
         check(rx[0], ST_ALL_BUSY);
         check({7'b0, progBusy}, 8'h01);
      end
      waitIdle();
   endtask : wr

   task automatic wrst(input logic [7:0] d);
      u_mst.xfer('{OPC_WRST, d}, 0, -1, rx);
      if (wel && !(pen && wpn == 1'b0)) {pen, bp} = {d[ST_PEN_BIT], d[ST_BPH_BIT:ST_BPL_BIT]};
      wel = 1'b0;
      waitIdle();
   endtask : wrst

   // Main sequence
   initial begin
      logic [7:0]  d[$];
      logic [15:0] a;
      void'($urandom(99470));
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check({7'b0, soOen}, 8'h01);
      rdst(-1);
      $display("test reset done");
      u_mst.xfer('{8'h0e}, 0, -1, rx);
      wel = 1'b1;
      rdst(-1);
      u_mst.xfer('{OPC_CLRWE}, 0, -1, rx);
      wel = 1'b0;
      rdst(12);
      we();
      wr(16'h0100, '{8'h5a});
      wr(16'h0100, '{8'h11});
      rd(16'h0100, 1);
      $display("test latch done");
      we();
      wr(16'hffff, '{8'ha1, 8'hb2});
      we();
      wr(16'hc000, '{8'hc3});
      rd(16'h3fff, 2);
      for (int t = 0; t < 4; t++) begin
         u_mst.setMode(t[0]);
         a = 16'($urandom);
         d = {};
         repeat (1 + $urandom % 66) d.push_back(8'($urandom));
         we();
         wr(a, d);
         rdst(-1);
         rd({a[15:6], 6'h00}, 64);
      end
      u_mst.setMode(1'b0);
      $display("test array done");
      we();
      u_mst.xfer('{8'h07, 8'h55}, 0, -1, rx);
      u_mst.xfer('{OPC_WRST}, 0, -1, rx);
      rdst(-1);
      wrst(8'hfc);
      rdst(-1);
      we();
      wr(16'h0100, '{8'h22});
      rd(16'h0100, 1);
      wpn <= 1'b0;
      we();
      wrst(8'h00);
      rdst(-1);
      wpn <= 1'b1;
      we();
      wrst(8'h04);
      rdst(-1);
      we();
      wr(16'h3fff, '{8'h33});
      rd(16'h3fff, 1);
      we();
      wr(16'h2fff, '{8'h44});
      rd(16'h2fff, 2);
      $display("test protect done");
      report_and_stop();
   end

   // Watchdog
   initial begin
      #900000;
      mismatches++;
      report_and_stop();
   end
endmodule : spi_eeprom_command_protect_tb
